// ===== core/engine_regs_pkg.sv
// Purpose: shared constants for the serial engine address filter and status block
// Assumes: byte offsets are word addresses on AXI4-Lite (offset * 4)
// Notes: offsets keep the printed register indices
package engine_regs_pkg;
  localparam logic [15:0] STATUS_INDEX = 16'h7f93;
  localparam logic [15:0] OVERRIDE_INDEX = 16'h7f94;
  localparam logic [15:0] ALIAS2_INDEX = 16'h7f9e;
  localparam logic [15:0] ALIAS3_INDEX = 16'h7f9f;
  localparam logic [15:0] PRIMARY_INDEX = 16'h7f92;
  localparam logic [15:0] ALIAS1_INDEX = 16'h7f99;
  localparam int ADDR_W = 18;
  localparam logic [7:0] STATUS_RESET = 8'h03;
  localparam logic [7:0] OVERRIDE_RESET = 8'h00;
  localparam logic [7:0] ALIAS_RESET = 8'h00;
  localparam int ALIAS_EN_BIT = 7;
  localparam int ST_ERR = 7;
  localparam int ST_TIMEOUT = 6;
  localparam int ST_SETUP = 5;
  localparam int ST_SOF = 4;
  localparam int ST_PRE = 3;
  localparam int ST_ACK = 2;
  localparam int ST_BUS_RESET = 1;
  localparam int ST_END = 0;
  localparam int CT_DMA_INHIBIT = 7;
  localparam int CT_FORCE_HANDSHAKE = 6;
  localparam int CT_FORCE_LAST_TX = 5;
  localparam int CT_FORCE_OVERFLOW = 4;
  localparam int CT_FORCE_ABORT = 3;
  localparam int CT_FORCE_END = 2;
  localparam int CT_RX_TAG = 1;
  localparam int CT_TX_OK = 0;
  localparam logic [3:0] ALIAS2_EP_LO = 4'h8;
  localparam logic [3:0] ALIAS2_EP_HI = 4'hb;
  localparam logic [3:0] ALIAS3_EP_LO = 4'hc;
  localparam logic [3:0] ALIAS3_EP_HI = 4'hf;
  localparam logic [3:0] PRIMARY_EP_LO = 4'h0;
  localparam logic [3:0] PRIMARY_EP_HI = 4'h3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : engine_regs_pkg

// ===== core/alias_match.sv
// Purpose: compares a decoded token against one address group
// Assumes: inputs are stable for the cycle of the compare
// Notes: combinational; the top registers the result
`timescale 1ns/100ps
module alias_match
(
  input wire logic enable,
  input wire logic [6:0] group_addr,
  input wire logic [3:0] ep_lo,
  input wire logic [3:0] ep_hi,
  input wire logic [6:0] token_addr,
  input wire logic [3:0] token_ep,
  output logic hit
);
  // a cleared enable masks the whole group, address bits ignored
  assign hit = enable && (token_addr == group_addr)
    && (token_ep >= ep_lo) && (token_ep <= ep_hi);
endmodule : alias_match

// ===== core/engine_status_ctrl.sv
// Purpose: address filter, status register and test overrides of the serial engine
// Assumes: engine status inputs come from logic on CLK; bus signals are AXI4-Lite
// Notes: registers answer at word address = printed index * 4
// Operation
// - Second alias enabled maps endpoints 8 to 11 to its address.
// - Third alias enabled maps endpoints 12 to 15 to its address.
// - A disabled alias never affects the endpoint match.
// - Alias low seven bits hold a read/write address, reset zero.
// - Status bit 7 reports an error, valid at end rising edge.
// - Status bit 6 reports an inter-packet timeout, valid at end edge.
// - Status bit 5 reports the last token was SETUP.
// - Status bit 4 reports start-of-frame, valid while end is low.
// - Status bit 3 reports SYNC followed by preamble PID.
// - Status bit 2 reports clean completion, valid at end edge.
// - Status bit 1 follows bus reset, set by system reset.
// - Status bit 0 rises at transaction end, falls at next start.
// - Status register is read-only, mirrors engine, resets to 0x03.
// - Control bit 7 inhibits the engine DMA path.
// - Control bit 6 forces an acknowledge during receive.
// - Control bit 5 tags next transmit byte as last.
// - Control bit 4 forces receive overflow and flush.
// - Control bit 3 aborts transmission with a stuffing error.
// - Control bit 2 forces transaction end.
// - Control bits 1 and 0 mirror receive tag and transmit ok.
// - Primary address reaches endpoints 0 to 3.
// - First alias enabled reaches endpoints 0 to 15.
`timescale 1ns/100ps
module engine_status_ctrl
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [17:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [17:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [6:0] PRIMARY_ADDR,
  input wire logic [7:0] FIRST_ALIAS,
  input wire logic TOKEN_VALID,
  input wire logic [6:0] TOKEN_ADDR,
  input wire logic [3:0] TOKEN_EP,
  input wire logic ENG_ERROR,
  input wire logic ENG_TIMEOUT,
  input wire logic ENG_SETUP,
  input wire logic ENG_SOF,
  input wire logic ENG_PRE,
  input wire logic ENG_ACK,
  input wire logic ENG_BUS_RESET,
  input wire logic ENG_TRANSACTION_END,
  input wire logic RECEIVE_TAG,
  input wire logic TRANSMIT_OK,
  output logic ENDPOINT_MATCH,
  output logic ENGINE_DMA_INHIBIT,
  output logic FORCE_RECEIVE_HANDSHAKE,
  output logic FORCE_LAST_TX_BYTE,
  output logic FORCE_RECEIVE_OVERFLOW,
  output logic FORCE_TRANSMIT_ABORT,
  output logic FORCE_TRANSACTION_END
);
  logic [7:0] second_alias;
  logic [7:0] third_alias;
  logic [7:0] override_ctl;
  logic [7:0] status;
  logic [1:0] view;
  logic aw_held;
  logic w_held;
  logic [17:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [3:0] hits;
  logic [7:0] next_read;
  logic read_ok;

  function automatic logic [17:0] word_addr(input logic [15:0] index);
    word_addr = {index, 2'b00};
  endfunction : word_addr

  // write channels may arrive in either order; each is held until both are in
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= engine_regs_pkg::RESP_OKAY;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (aw_held && w_held && !S_AXI_BVALID)
      begin
        S_AXI_BVALID <= 1'b1;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        if (aw_addr == word_addr(engine_regs_pkg::ALIAS2_INDEX)
            || aw_addr == word_addr(engine_regs_pkg::ALIAS3_INDEX)
            || aw_addr == word_addr(engine_regs_pkg::OVERRIDE_INDEX)
            || aw_addr == word_addr(engine_regs_pkg::STATUS_INDEX))
          S_AXI_BRESP <= engine_regs_pkg::RESP_OKAY;
        else
          S_AXI_BRESP <= engine_regs_pkg::RESP_SLVERR;
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
    end
    else
    begin
      S_AXI_AWREADY <= !aw_held && !(S_AXI_AWVALID && S_AXI_AWREADY) && !S_AXI_BVALID;
      S_AXI_WREADY <= !w_held && !(S_AXI_WVALID && S_AXI_WREADY) && !S_AXI_BVALID;
    end
  end

  logic do_write;
  assign do_write = aw_held && w_held && !S_AXI_BVALID && w_strb[0];

  // alias registers: full 8 bits read/write, enable in bit 7
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      second_alias <= engine_regs_pkg::ALIAS_RESET;
      third_alias <= engine_regs_pkg::ALIAS_RESET;
    end
    else if (do_write)
    begin
      if (aw_addr == word_addr(engine_regs_pkg::ALIAS2_INDEX))
        second_alias <= w_data[7:0];
      if (aw_addr == word_addr(engine_regs_pkg::ALIAS3_INDEX))
        third_alias <= w_data[7:0];
    end
  end

  // only bits 7:2 are stored; 1:0 are live views
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      override_ctl <= engine_regs_pkg::OVERRIDE_RESET;
    else if (do_write && aw_addr == word_addr(engine_regs_pkg::OVERRIDE_INDEX))
      override_ctl <= {w_data[7:2], 2'b00};
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      ENGINE_DMA_INHIBIT <= 1'b0;
      FORCE_RECEIVE_HANDSHAKE <= 1'b0;
      FORCE_LAST_TX_BYTE <= 1'b0;
      FORCE_RECEIVE_OVERFLOW <= 1'b0;
      FORCE_TRANSMIT_ABORT <= 1'b0;
      FORCE_TRANSACTION_END <= 1'b0;
    end
    else
    begin
      ENGINE_DMA_INHIBIT <= override_ctl[engine_regs_pkg::CT_DMA_INHIBIT];
      FORCE_RECEIVE_HANDSHAKE <= override_ctl[engine_regs_pkg::CT_FORCE_HANDSHAKE];
      FORCE_LAST_TX_BYTE <= override_ctl[engine_regs_pkg::CT_FORCE_LAST_TX];
      FORCE_RECEIVE_OVERFLOW <= override_ctl[engine_regs_pkg::CT_FORCE_OVERFLOW];
      FORCE_TRANSMIT_ABORT <= override_ctl[engine_regs_pkg::CT_FORCE_ABORT];
      FORCE_TRANSACTION_END <= override_ctl[engine_regs_pkg::CT_FORCE_END];
    end
  end

  // status mirrors the engine one cycle late; writes never touch it
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      status <= engine_regs_pkg::STATUS_RESET;
      view <= 2'b00;
    end
    else
    begin
      status[engine_regs_pkg::ST_ERR] <= ENG_ERROR;
      status[engine_regs_pkg::ST_TIMEOUT] <= ENG_TIMEOUT;
      status[engine_regs_pkg::ST_SETUP] <= ENG_SETUP;
      status[engine_regs_pkg::ST_SOF] <= ENG_SOF;
      status[engine_regs_pkg::ST_PRE] <= ENG_PRE;
      status[engine_regs_pkg::ST_ACK] <= ENG_ACK;
      status[engine_regs_pkg::ST_BUS_RESET] <= ENG_BUS_RESET;
      status[engine_regs_pkg::ST_END] <= ENG_TRANSACTION_END;
      view <= {RECEIVE_TAG, TRANSMIT_OK};
    end
  end

  always_comb
  begin
    next_read = 8'h00;
    read_ok = 1'b1;
    if (S_AXI_ARADDR == word_addr(engine_regs_pkg::STATUS_INDEX))
      next_read = status;
    else if (S_AXI_ARADDR == word_addr(engine_regs_pkg::OVERRIDE_INDEX))
      next_read = {override_ctl[7:2], view};
    else if (S_AXI_ARADDR == word_addr(engine_regs_pkg::ALIAS2_INDEX))
      next_read = second_alias;
    else if (S_AXI_ARADDR == word_addr(engine_regs_pkg::ALIAS3_INDEX))
      next_read = third_alias;
    else
      read_ok = 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= engine_regs_pkg::RESP_OKAY;
    end
    else
    begin
      S_AXI_ARREADY <= 1'b0;
      if (S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID)
        S_AXI_ARREADY <= 1'b1;
      // read data only after the address handshake, never in the same cycle
      if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= {24'h000000, next_read};
        S_AXI_RRESP <= read_ok ? engine_regs_pkg::RESP_OKAY : engine_regs_pkg::RESP_SLVERR;
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
    end
  end

  // group 0 primary, 1 first alias, 2 second alias, 3 third alias
  logic [3:0] grp_en;
  logic [6:0] grp_addr [4];
  logic [3:0] grp_lo [4];
  logic [3:0] grp_hi [4];
  assign grp_en = {third_alias[engine_regs_pkg::ALIAS_EN_BIT],
    second_alias[engine_regs_pkg::ALIAS_EN_BIT],
    FIRST_ALIAS[engine_regs_pkg::ALIAS_EN_BIT], 1'b1};
  assign grp_addr[0] = PRIMARY_ADDR;
  assign grp_addr[1] = FIRST_ALIAS[6:0];
  assign grp_addr[2] = second_alias[6:0];
  assign grp_addr[3] = third_alias[6:0];
  assign grp_lo[0] = engine_regs_pkg::PRIMARY_EP_LO;
  assign grp_hi[0] = engine_regs_pkg::PRIMARY_EP_HI;
  assign grp_lo[1] = 4'h0;
  assign grp_hi[1] = 4'hf;
  assign grp_lo[2] = engine_regs_pkg::ALIAS2_EP_LO;
  assign grp_hi[2] = engine_regs_pkg::ALIAS2_EP_HI;
  assign grp_lo[3] = engine_regs_pkg::ALIAS3_EP_LO;
  assign grp_hi[3] = engine_regs_pkg::ALIAS3_EP_HI;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : group
      alias_match u_match
      (
        .enable(grp_en[g]),
        .group_addr(grp_addr[g]),
        .ep_lo(grp_lo[g]),
        .ep_hi(grp_hi[g]),
        .token_addr(TOKEN_ADDR),
        .token_ep(TOKEN_EP),
        .hit(hits[g])
      );
    end
  endgenerate

  // overlap between groups is firmware's to avoid; an OR is safe either way
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      ENDPOINT_MATCH <= 1'b0;
    else
      ENDPOINT_MATCH <= TOKEN_VALID && (|hits);
  end

  a_second_alias_hit: assert property (@(posedge CLK) disable iff (!RST_B)
    TOKEN_VALID && second_alias[7] && TOKEN_ADDR == second_alias[6:0]
    && TOKEN_EP >= 4'h8 && TOKEN_EP <= 4'hb |=> ENDPOINT_MATCH)
    else $error("second alias token not matched");
  a_third_alias_hit: assert property (@(posedge CLK) disable iff (!RST_B)
    TOKEN_VALID && third_alias[7] && TOKEN_ADDR == third_alias[6:0]
    && TOKEN_EP >= 4'hc |=> ENDPOINT_MATCH)
    else $error("third alias token not matched");
  a_disabled_no_match: assert property (@(posedge CLK) disable iff (!RST_B)
    !FIRST_ALIAS[7] && TOKEN_ADDR != PRIMARY_ADDR
    && !(second_alias[7] && TOKEN_ADDR == second_alias[6:0])
    && !(third_alias[7] && TOKEN_ADDR == third_alias[6:0]) |=> !ENDPOINT_MATCH)
    else $error("match from a disabled group");
  a_primary_range: assert property (@(posedge CLK) disable iff (!RST_B)
    TOKEN_VALID && TOKEN_ADDR == PRIMARY_ADDR && TOKEN_EP <= 4'h3 |=> ENDPOINT_MATCH)
    else $error("primary token not matched");
  a_status_mirror: assert property (@(posedge CLK) disable iff (!RST_B)
    ##1 status == {$past(ENG_ERROR), $past(ENG_TIMEOUT), $past(ENG_SETUP), $past(ENG_SOF),
    $past(ENG_PRE), $past(ENG_ACK), $past(ENG_BUS_RESET), $past(ENG_TRANSACTION_END)})
    else $error("status does not mirror engine");
  a_end_rise_seen: assert property (@(posedge CLK) disable iff (!RST_B)
    $rose(ENG_TRANSACTION_END) |=> status[0] ##0 status[2] == $past(ENG_ACK))
    else $error("transaction end not reflected with ack");
  a_status_reset: assert property (@(posedge CLK)
    !RST_B |=> status == 8'h03)
    else $error("status reset value wrong");
  a_dma_inhibit: assert property (@(posedge CLK) disable iff (!RST_B)
    override_ctl[7] |=> ENGINE_DMA_INHIBIT)
    else $error("dma inhibit not driven");
  a_force_out: assert property (@(posedge CLK) disable iff (!RST_B)
    ##1 {FORCE_RECEIVE_HANDSHAKE, FORCE_LAST_TX_BYTE, FORCE_RECEIVE_OVERFLOW,
    FORCE_TRANSMIT_ABORT, FORCE_TRANSACTION_END} == $past(override_ctl[6:2]))
    else $error("force outputs disagree with control");
  a_alias_write: assert property (@(posedge CLK) disable iff (!RST_B)
    do_write && aw_addr == word_addr(engine_regs_pkg::ALIAS2_INDEX)
    |=> second_alias == $past(w_data[7:0]))
    else $error("alias write lost");

  c_alias_match: cover property (@(posedge CLK) disable iff (!RST_B)
    TOKEN_VALID && hits[2] ##1 ENDPOINT_MATCH);
  c_status_read: cover property (@(posedge CLK) disable iff (!RST_B)
    S_AXI_RVALID && S_AXI_RREADY && S_AXI_RDATA[0]);
  c_override_write: cover property (@(posedge CLK) disable iff (!RST_B)
    ENGINE_DMA_INHIBIT && FORCE_TRANSACTION_END);
endmodule : engine_status_ctrl

// ===== testbench/engine_side_model.sv
// Purpose: engine and bus side stand-in that feeds tokens and status levels
// Assumes: one clock; levels change right after a rising edge
// Notes: idle token lines carry the inverted last value so stale data never matches
`timescale 1ns/100ps
module engine_side_model
#(
  parameter logic [6:0] PRIMARY = 7'h11
)
(
  input wire logic clk,
  output logic token_valid,
  output logic [6:0] token_addr,
  output logic [3:0] token_ep,
  output logic [7:0] status,
  output logic [1:0] views,
  output logic [6:0] primary_addr,
  output logic [7:0] first_alias
);
  initial
  begin
    {token_valid, token_addr, token_ep} = 12'h000;
    status = 8'h03;
    views = 2'b00;
    primary_addr = PRIMARY;
    first_alias = 8'h40;
  end

  // one token per call, valid for exactly one edge
  task send_token(input logic [6:0] a, input logic [3:0] e);
    @(posedge clk);
    token_valid <= 1'b1;
    token_addr <= a;
    token_ep <= e;
    @(posedge clk);
    token_valid <= 1'b0;
    token_addr <= ~a;
    token_ep <= ~e;
  endtask : send_token

  task set_levels(input logic [7:0] s, input logic [1:0] v, input logic [7:0] fa);
    @(posedge clk);
    status <= s;
    views <= v;
    first_alias <= fa;
  endtask : set_levels
endmodule : engine_side_model

// ===== testbench/tb_top.sv
// Purpose: register and token tests of the address filter and status block
// Assumes: register byte address is index * 4; answers sampled before each edge
// Notes: readies are read at the falling edge, where they match the next rising edge
`timescale 1ns/100ps
module tb_top;
  logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, match, tv;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, tep;
  logic [1:0] bresp, rresp, views, rsp;
  logic [5:0] ctl;
  logic [6:0] taddr, primary;
  logic [7:0] status, alias1, rd;
  int error_cnt, check_count, i;

  engine_side_model model (.clk(clk), .token_valid(tv), .token_addr(taddr), .token_ep(tep),
    .status(status), .views(views), .primary_addr(primary), .first_alias(alias1));

  engine_status_ctrl dut (.CLK(clk), .RST_B(rst_b),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .PRIMARY_ADDR(primary), .FIRST_ALIAS(alias1),
    .TOKEN_VALID(tv), .TOKEN_ADDR(taddr), .TOKEN_EP(tep),
    .ENG_ERROR(status[7]), .ENG_TIMEOUT(status[6]), .ENG_SETUP(status[5]),
    .ENG_SOF(status[4]), .ENG_PRE(status[3]), .ENG_ACK(status[2]),
    .ENG_BUS_RESET(status[1]), .ENG_TRANSACTION_END(status[0]),
    .RECEIVE_TAG(views[1]), .TRANSMIT_OK(views[0]), .ENDPOINT_MATCH(match),
    .ENGINE_DMA_INHIBIT(ctl[5]), .FORCE_RECEIVE_HANDSHAKE(ctl[4]),
    .FORCE_LAST_TX_BYTE(ctl[3]), .FORCE_RECEIVE_OVERFLOW(ctl[2]),
    .FORCE_TRANSMIT_ABORT(ctl[1]), .FORCE_TRANSACTION_END(ctl[0]));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task end_of_test;
    $display("counts: checks=%0d mismatches=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk

  task guard(input logic ok);
    if (!ok)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h (no answer)", $time, 1'b0, 1'b1);
      error_cnt++;
      end_of_test();
    end
  endtask : guard

  // address and data offered together; bready held until the answer
  task wr(input logic [15:0] idx, input logic [7:0] d, input logic [3:0] s);
    logic aw_hit, w_hit, b_hit;
    int n;
    b_hit = 1'b0;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    wstrb <= s;
    {awvalid, wvalid, bready} <= 3'b111;
    for (n = 0; n < 50 && !b_hit; n++)
    begin
      @(negedge clk);
      aw_hit = awvalid && awready;
      w_hit = wvalid && wready;
      b_hit = bvalid;
      rsp = bresp;
      @(posedge clk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    guard(b_hit);
  endtask : wr

  task rd_chk(input logic [15:0] idx, input logic [7:0] exp);
    logic ar_hit, r_hit;
    int n;
    r_hit = 1'b0;
    @(posedge clk);
    araddr <= {idx, 2'b00};
    {arvalid, rready} <= 2'b11;
    for (n = 0; n < 50 && !r_hit; n++)
    begin
      @(negedge clk);
      ar_hit = arvalid && arready;
      r_hit = rvalid;
      rd = rdata[7:0];
      rsp = rresp;
      @(posedge clk);
      if (ar_hit) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    guard(r_hit);
    chk(rd, exp);
  endtask : rd_chk

  task tok(input logic [6:0] a, input logic [3:0] e, input logic x);
    model.send_token(a, e);
    #1;
    chk({7'h00, match}, {7'h00, x});
  endtask : tok

  initial
  begin
    error_cnt = 0;
    check_count = 0;
    rst_b = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'b00000;
    {awaddr, araddr, wdata, wstrb} = 72'h0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk(engine_regs_pkg::STATUS_INDEX, 8'h03);
    rd_chk(engine_regs_pkg::OVERRIDE_INDEX, 8'h00);
    rd_chk(engine_regs_pkg::ALIAS2_INDEX, 8'h00);
    rd_chk(engine_regs_pkg::ALIAS3_INDEX, 8'h00);
    $display("test reset values done");
    wr(engine_regs_pkg::STATUS_INDEX, 8'hff, 4'h1);
    chk({6'h00, rsp}, {6'h00, engine_regs_pkg::RESP_OKAY});
    rd_chk(engine_regs_pkg::STATUS_INDEX, 8'h03);
    for (i = 0; i < 8; i++)
    begin
      model.set_levels(8'h01 << i, 2'b00, 8'h40);
      repeat (2) @(posedge clk);
      rd_chk(engine_regs_pkg::STATUS_INDEX, 8'h01 << i);
    end
    // end rises together with ack, so the end-edge assertion gets exercised
    model.set_levels(8'h05, 2'b00, 8'h40);
    repeat (2) @(posedge clk);
    rd_chk(engine_regs_pkg::STATUS_INDEX, 8'h05);
    $display("test status mirror done");
    for (i = 2; i < 8; i++)
    begin
      wr(engine_regs_pkg::OVERRIDE_INDEX, 8'h01 << i, 4'h1);
      chk({6'h00, rsp}, {6'h00, engine_regs_pkg::RESP_OKAY});
      repeat (2) @(posedge clk);
      #1;
      chk({ctl, 2'b00}, 8'h01 << i);
      rd_chk(engine_regs_pkg::OVERRIDE_INDEX, 8'h01 << i);
    end
    wr(engine_regs_pkg::OVERRIDE_INDEX, 8'h84, 4'h1);
    repeat (2) @(posedge clk);
    #1;
    chk({ctl, 2'b00}, 8'h84);
    model.set_levels(8'h00, 2'b10, 8'h40);
    wr(engine_regs_pkg::OVERRIDE_INDEX, 8'h03, 4'h1);
    rd_chk(engine_regs_pkg::OVERRIDE_INDEX, 8'h02);
    model.set_levels(8'h00, 2'b01, 8'h40);
    wr(engine_regs_pkg::OVERRIDE_INDEX, 8'hfc, 4'h0);
    repeat (2) @(posedge clk);
    #1;
    chk({ctl, 2'b00}, 8'h00);
    rd_chk(engine_regs_pkg::OVERRIDE_INDEX, 8'h01);
    $display("test override control done");
    // groups kept apart: primary 0x11, alias2 0x25, alias3 0x33, alias1 0x40
    wr(engine_regs_pkg::ALIAS2_INDEX, 8'ha5, 4'h1);
    wr(engine_regs_pkg::ALIAS3_INDEX, 8'hb3, 4'h1);
    rd_chk(engine_regs_pkg::ALIAS2_INDEX, 8'ha5);
    rd_chk(engine_regs_pkg::ALIAS3_INDEX, 8'hb3);
    tok(7'h25, 4'h7, 1'b0);
    tok(7'h25, 4'h8, 1'b1);
    tok(7'h25, 4'hb, 1'b1);
    tok(7'h25, 4'hc, 1'b0);
    tok(7'h26, 4'h8, 1'b0);
    tok(7'h33, 4'hb, 1'b0);
    tok(7'h33, 4'hc, 1'b1);
    tok(7'h33, 4'hf, 1'b1);
    tok(7'h11, 4'h3, 1'b1);
    tok(7'h11, 4'h4, 1'b0);
    tok(7'h40, 4'hf, 1'b0);
    @(posedge clk);
    #1;
    chk({7'h00, match}, 8'h00);
    model.set_levels(8'h00, 2'b00, 8'hc0);
    tok(7'h40, 4'hf, 1'b1);
    tok(7'h40, 4'h0, 1'b1);
    wr(engine_regs_pkg::ALIAS2_INDEX, 8'h25, 4'h1);
    tok(7'h25, 4'h8, 1'b0);
    rd_chk(engine_regs_pkg::ALIAS2_INDEX, 8'h25);
    $display("test address match done");
    rd_chk(16'h7f95, 8'h00);
    chk({6'h00, rsp}, {6'h00, engine_regs_pkg::RESP_SLVERR});
    wr(16'h7f95, 8'h5a, 4'h1);
    chk({6'h00, rsp}, {6'h00, engine_regs_pkg::RESP_SLVERR});
    $display("test unmapped access done");
    end_of_test();
  end
endmodule : tb_top
